// *** csf_consts.svh ***
// Constants of the controller status flag block: offsets, fields, resets
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH

// ********************
// Register offsets
// ********************
`define CSF_OFS_POS_PRI 8'h00
`define CSF_OFS_MSTEP 8'h04
`define CSF_OFS_POS_SEC 8'h08
`define CSF_OFS_SPD_PRI 8'h0c
`define CSF_OFS_SPD_MSTEP 8'h10
`define CSF_OFS_SUP_I 8'h14
`define CSF_OFS_SUP_V 8'h18
`define CSF_OFS_USB_I 8'h1c
`define CSF_OFS_USB_V 8'h20
`define CSF_OFS_TEMP 8'h24
`define CSF_OFS_FLAGS 8'h28
`define CSF_OFS_GPIO 8'h2c
`define CSF_OFS_CTRL 8'h30
`define CSF_OFS_INV 8'h34
`define CSF_OFS_QUERY 8'h38

// ********************
// Flag word fields
// ********************
`define CSF_F_ERR_CMD 0
`define CSF_F_ERR_CRC 1
`define CSF_F_ERR_VAL 2
`define CSF_F_ALARM 3
`define CSF_F_CRIT_LO 4
`define CSF_F_SW_MIX 12
`define CSF_F_DESYNC 13
`define CSF_F_MEM_STAGE 14
`define CSF_F_EXT_PWR 15

// Digital word fields
`define CSF_G_LIM_R 0
`define CSF_G_LIM_L 1
`define CSF_G_BTN_R 2
`define CSF_G_BTN_L 3
`define CSF_G_EXTERNAL_IO_PIN_OUT 4
`define CSF_G_EXTERNAL_IO_PIN_ACT 5
`define CSF_G_HALL_LO 6
`define CSF_G_BRAKE 9
`define CSF_G_REV 10
`define CSF_G_SYNC_IN 11
`define CSF_G_SYNC_OUT 12
`define CSF_G_ENC_A 13
`define CSF_G_ENC_B 14

// Control word fields
`define CSF_C_MODE_LO 0
`define CSF_C_CORR 2
`define CSF_C_STOP 3

// ********************
// Reset values and field widths
// ********************
`define CSF_CTRL_RST 32'h0000_0000
`define CSF_INV_RST 32'h0000_0000
`define CSF_FLAGS_RST 32'h0000_8000
`define CSF_CRIT_N 8
`define CSF_INV_N 8

`endif

// *** csf_pkg.sv ***
// Types of the controller status flag block
package csf_pkg;
  typedef enum logic [1:0] {
    CSF_OPEN_LOOP,
    CSF_LEAD_ENC,
    CSF_STEP_FB,
    CSF_DC
  } csf_mode_t;
endpackage

// *** csf_status.sv ***
// Status snapshot register bank of the motor controller
`include "csf_consts.svh"

module csf_status
  import csf_pkg::*;
#(
  parameter int POS_W = 32,
  parameter int MEAS_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Live motion values
  input wire logic [POS_W-1:0] step_count_i,
  input wire logic [8:0] microstep_count_i,
  input wire logic [POS_W-1:0] encoder_count_i,
  input wire logic [POS_W-1:0] step_speed_i,
  input wire logic [8:0] microstep_speed_i,
  input wire logic [POS_W-1:0] encoder_speed_i,
  // Measurements, already scaled
  input wire logic [MEAS_W-1:0] sup_current_ma_i,
  input wire logic [MEAS_W-1:0] sup_voltage_10mv_i,
  input wire logic [MEAS_W-1:0] usb_current_ma_i,
  input wire logic [MEAS_W-1:0] usb_voltage_10mv_i,
  input wire logic [MEAS_W-1:0] temp_dc_i,
  // Error events, one-cycle pulses
  input wire logic unknown_command_i,
  input wire logic bad_check_code_i,
  input wire logic bad_value_i,
  input wire logic stop_cmd_i,
  input wire logic switch_swap_i,
  input wire logic desync_i,
  // Levels
  input wire logic alarm_i,
  input wire logic [7:0] crit_cond_i,
  input wire logic [7:0] crit_autoclr_i,
  input wire logic mem_stage_i,
  // Raw pins
  input wire logic lim_r_i,
  input wire logic lim_l_i,
  input wire logic btn_r_i,
  input wire logic btn_l_i,
  input wire logic external_io_pin_dir_out_i,
  input wire logic external_io_pin_level_i,
  input wire logic [2:0] hall_i,
  input wire logic brake_pwr_i,
  input wire logic rev_i,
  input wire logic sync_in_i,
  input wire logic sync_out_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  output logic query_done_o
);

  // ********************
  // Control registers
  // ********************
  logic [31:0] ctrl_reg;
  logic [31:0] inv_reg;
  csf_mode_t mode;
  logic corr_en;
  logic sw_stop;
  logic query;
  logic stop_any;
  logic wr_ctrl;
  logic wr_inv;

  assign mode = csf_mode_t'(ctrl_reg[`CSF_C_MODE_LO +: 2]);
  assign corr_en = ctrl_reg[`CSF_C_CORR];
  assign wr_ctrl = wr_i && addr_i == `CSF_OFS_CTRL;
  assign wr_inv = wr_i && addr_i == `CSF_OFS_INV;
  // Stop acts once and is not stored, so a later read cannot replay it
  assign sw_stop = wr_ctrl && wdata_i[`CSF_C_STOP];
  assign query = wr_i && addr_i == `CSF_OFS_QUERY;
  assign stop_any = stop_cmd_i | sw_stop;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_reg <= `CSF_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= {29'h0000_0000, wdata_i[2:0]};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      inv_reg <= `CSF_INV_RST;
    end else if (wr_inv) begin
      inv_reg <= {24'h00_0000, wdata_i[7:0]};
    end
  end

  // ********************
  // Sticky and self-clearing flags
  // ********************
  logic err_cmd_reg;
  logic err_crc_reg;
  logic err_val_reg;
  logic sw_mix_reg;
  logic desync_reg;
  logic [`CSF_CRIT_N-1:0] crit_reg;

  // Set wins over stop so a coincident event survives
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_cmd_reg <= 1'b0;
    end else begin
      err_cmd_reg <= unknown_command_i | (err_cmd_reg & ~stop_any);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_crc_reg <= 1'b0;
    end else begin
      err_crc_reg <= bad_check_code_i | (err_crc_reg & ~stop_any);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_val_reg <= 1'b0;
    end else begin
      err_val_reg <= bad_value_i | (err_val_reg & ~stop_any);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sw_mix_reg <= 1'b0;
    end else begin
      sw_mix_reg <= switch_swap_i | (sw_mix_reg & ~stop_any);
    end
  end

  // With correction on the flag follows the live mismatch
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      desync_reg <= 1'b0;
    end else if (corr_en) begin
      desync_reg <= desync_i;
    end else begin
      desync_reg <= desync_i | (desync_reg & ~stop_any);
    end
  end

  // Auto-clear bits mirror the condition; others latch until stop
  genvar gi;
  generate
    for (gi = 0; gi < `CSF_CRIT_N; gi++) begin : g_crit
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          crit_reg[gi] <= 1'b0;
        end else if (crit_autoclr_i[gi]) begin
          crit_reg[gi] <= crit_cond_i[gi];
        end else begin
          crit_reg[gi] <= crit_cond_i[gi] | (crit_reg[gi] & ~stop_any);
        end
      end
    end
  endgenerate

  // ********************
  // Live field selection
  // ********************
  logic [POS_W-1:0] pos_pri_next;
  logic [8:0] mstep_next;
  logic [POS_W-1:0] pos_sec_next;
  logic [POS_W-1:0] spd_pri_next;
  logic [8:0] mspd_next;

  always_comb begin
    pos_pri_next = step_count_i;
    mstep_next = microstep_count_i;
    pos_sec_next = encoder_count_i;
    spd_pri_next = step_speed_i;
    mspd_next = microstep_speed_i;
    case (mode)
      CSF_OPEN_LOOP: begin
        pos_sec_next = encoder_count_i;
      end
      CSF_LEAD_ENC: begin
        pos_pri_next = encoder_count_i;
        mstep_next = 9'h000;
        pos_sec_next = step_count_i;
        spd_pri_next = encoder_speed_i;
        mspd_next = 9'h000;
      end
      CSF_STEP_FB: begin
        pos_sec_next = step_count_i;
      end
      CSF_DC: begin
        pos_pri_next = encoder_count_i;
        mstep_next = 9'h000;
        pos_sec_next = '0;
        spd_pri_next = encoder_speed_i;
        mspd_next = 9'h000;
      end
      default: begin
        pos_sec_next = '0;
      end
    endcase
  end

  // Inverted-polarity pins become active-high flags
  logic [`CSF_INV_N-1:0] act_raw;
  logic [`CSF_INV_N-1:0] act;
  assign act_raw = {sync_out_i, sync_in_i, rev_i, external_io_pin_level_i,
                    btn_l_i, btn_r_i, lim_l_i, lim_r_i};
  assign act = act_raw ^ inv_reg[`CSF_INV_N-1:0];

  logic [31:0] flags_next;
  logic [31:0] gpio_next;

  always_comb begin
    flags_next = 32'h0000_0000;
    flags_next[`CSF_F_ERR_CMD] = err_cmd_reg;
    flags_next[`CSF_F_ERR_CRC] = err_crc_reg;
    flags_next[`CSF_F_ERR_VAL] = err_val_reg;
    flags_next[`CSF_F_ALARM] = alarm_i;
    flags_next[`CSF_F_CRIT_LO +: `CSF_CRIT_N] = crit_reg;
    flags_next[`CSF_F_SW_MIX] = sw_mix_reg;
    flags_next[`CSF_F_DESYNC] = desync_reg;
    flags_next[`CSF_F_MEM_STAGE] = mem_stage_i;
    flags_next[`CSF_F_EXT_PWR] = 1'b1;
    gpio_next = 32'h0000_0000;
    gpio_next[`CSF_G_LIM_R] = act[0];
    gpio_next[`CSF_G_LIM_L] = act[1];
    gpio_next[`CSF_G_BTN_R] = act[2];
    gpio_next[`CSF_G_BTN_L] = act[3];
    gpio_next[`CSF_G_EXTERNAL_IO_PIN_OUT] = external_io_pin_dir_out_i;
    gpio_next[`CSF_G_EXTERNAL_IO_PIN_ACT] = act[4];
    gpio_next[`CSF_G_HALL_LO +: 3] = hall_i;
    gpio_next[`CSF_G_BRAKE] = brake_pwr_i;
    gpio_next[`CSF_G_REV] = act[5];
    gpio_next[`CSF_G_SYNC_IN] = act[6];
    gpio_next[`CSF_G_SYNC_OUT] = act[7];
    gpio_next[`CSF_G_ENC_A] = enc_a_i;
    gpio_next[`CSF_G_ENC_B] = enc_b_i;
  end

  // ********************
  // Snapshot on query
  // ********************
  // One-cycle capture keeps position, speed and flags mutually coherent
  logic [POS_W-1:0] pos_pri_reg;
  logic [8:0] mstep_reg;
  logic [POS_W-1:0] pos_sec_reg;
  logic [POS_W-1:0] spd_pri_reg;
  logic [8:0] mspd_reg;
  logic [MEAS_W-1:0] sup_i_reg;
  logic [MEAS_W-1:0] sup_v_reg;
  logic [MEAS_W-1:0] usb_i_reg;
  logic [MEAS_W-1:0] usb_v_reg;
  logic [MEAS_W-1:0] temp_reg;
  logic [31:0] flags_reg;
  logic [31:0] gpio_reg;
  logic done_reg;

  // Position and speed share the capture edge with the flags
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pos_pri_reg <= '0;
      mstep_reg <= 9'h000;
      pos_sec_reg <= '0;
      spd_pri_reg <= '0;
      mspd_reg <= 9'h000;
    end else if (query) begin
      pos_pri_reg <= pos_pri_next;
      mstep_reg <= mstep_next;
      pos_sec_reg <= pos_sec_next;
      spd_pri_reg <= spd_pri_next;
      mspd_reg <= mspd_next;
    end
  end

  // Measurements arrive already scaled; no unit conversion here
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sup_i_reg <= '0;
      sup_v_reg <= '0;
      usb_i_reg <= '0;
      usb_v_reg <= '0;
      temp_reg <= '0;
    end else if (query) begin
      sup_i_reg <= sup_current_ma_i;
      sup_v_reg <= sup_voltage_10mv_i;
      usb_i_reg <= usb_current_ma_i;
      usb_v_reg <= usb_voltage_10mv_i;
      temp_reg <= temp_dc_i;
    end
  end

  // External-power bit is set from reset so it never reads clear
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_reg <= `CSF_FLAGS_RST;
      gpio_reg <= 32'h0000_0000;
    end else if (query) begin
      flags_reg <= flags_next;
      gpio_reg <= gpio_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= query;
    end
  end
  assign query_done_o = done_reg;

  // ********************
  // Read port
  // ********************
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (addr_i)
      `CSF_OFS_POS_PRI: rdata_next = 32'(pos_pri_reg);
      `CSF_OFS_MSTEP: rdata_next = {23'h00_0000, mstep_reg};
      `CSF_OFS_POS_SEC: rdata_next = 32'(pos_sec_reg);
      `CSF_OFS_SPD_PRI: rdata_next = 32'(spd_pri_reg);
      `CSF_OFS_SPD_MSTEP: rdata_next = {23'h00_0000, mspd_reg};
      `CSF_OFS_SUP_I: rdata_next = 32'(sup_i_reg);
      `CSF_OFS_SUP_V: rdata_next = 32'(sup_v_reg);
      `CSF_OFS_USB_I: rdata_next = 32'(usb_i_reg);
      `CSF_OFS_USB_V: rdata_next = 32'(usb_v_reg);
      `CSF_OFS_TEMP: rdata_next = 32'(temp_reg);
      `CSF_OFS_FLAGS: rdata_next = flags_reg;
      `CSF_OFS_GPIO: rdata_next = gpio_reg;
      `CSF_OFS_CTRL: rdata_next = ctrl_reg;
      `CSF_OFS_INV: rdata_next = inv_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

endmodule

// *** csf_status_assertions.sv ***
// Concurrent checks on the status snapshot block ports
module csf_status_checker #(
  parameter int POS_W = 32,
  parameter int MEAS_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic query_done_o,
  input wire logic [MEAS_W-1:0] temp_dc_i,
  input wire logic [2:0] hall_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic unknown_command_i,
  input wire logic bad_check_code_i,
  input wire logic bad_value_i,
  input wire logic stop_cmd_i,
  input wire logic alarm_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Reference snapshot
  // ********************
  logic [2:0] err_live;
  logic [3:0] snap_flg;
  logic [4:0] snap_raw;
  logic [MEAS_W-1:0] snap_temp;
  wire query = wr_i && addr_i == 8'h38;
  wire stop = stop_cmd_i || (wr_i && addr_i == 8'h30 && wdata_i[3]);
  // Set beats stop, so the set term is or-ed outside the stop mask
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_live <= 3'h0;
    end else begin
      err_live <= {bad_value_i, bad_check_code_i, unknown_command_i} | (err_live & {3{!stop}});
    end
  end
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      snap_flg <= 4'h0;
      snap_raw <= 5'h0;
      snap_temp <= '0;
    end else if (query) begin
      snap_flg <= {alarm_i, err_live};
      snap_raw <= {enc_b_i, enc_a_i, hall_i};
      snap_temp <= temp_dc_i;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  a_query_done_pulse: assert property (query |=> query_done_o)
    else $error("query done missing");
  a_done_needs_query: assert property (query_done_o |-> $past(query))
    else $error("query done without query");
  a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero");
  a_unmapped_read_zero: assert property (rd_i && addr_i >= 8'h3c |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_ext_power_set: assert property (rd_i && addr_i == 8'h28 |=> rdata_o[15])
    else $error("external power flag clear");
  a_temp_snapshot: assert property (rd_i && addr_i == 8'h24 |=> rdata_o == 32'(snap_temp))
    else $error("temperature snapshot wrong");
  a_raw_pin_levels: assert property (rd_i && addr_i == 8'h2c |=>
    {rdata_o[14:13], rdata_o[8:6]} == snap_raw) else $error("raw pin level wrong");
  a_error_flags: assert property (rd_i && addr_i == 8'h28 |=>
    rdata_o[3:0] == snap_flg) else $error("error flags wrong");
  c_query: cover property (query_done_o);
  c_flag_read: cover property (rd_i && addr_i == 8'h28 && snap_flg != 4'h0);
  c_stop: cover property (stop);
endmodule

bind csf_status csf_status_checker #(.POS_W(POS_W), .MEAS_W(MEAS_W)) u_chk (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .query_done_o(query_done_o),
  .temp_dc_i(temp_dc_i), .hall_i(hall_i), .enc_a_i(enc_a_i), .enc_b_i(enc_b_i),
  .unknown_command_i(unknown_command_i), .bad_check_code_i(bad_check_code_i),
  .bad_value_i(bad_value_i), .stop_cmd_i(stop_cmd_i), .alarm_i(alarm_i)
);

// *** csf_status_bench.sv ***
// Self-checking bench of the status snapshot block
module csf_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, query_done_o;
  logic [7:0] addr_i = '0, crit_cond_i = '0, crit_autoclr_i = '0;
  logic [31:0] wdata_i = '0, rdata_o, step_count_i = '0, encoder_count_i = '0;
  logic [31:0] step_speed_i = '0, encoder_speed_i = '0;
  logic [8:0] microstep_count_i = '0, microstep_speed_i = '0;
  logic [15:0] sup_current_ma_i = '0, sup_voltage_10mv_i = '0, usb_current_ma_i = '0;
  logic [15:0] usb_voltage_10mv_i = '0, temp_dc_i = '0;
  logic unknown_command_i = 0, bad_check_code_i = 0, bad_value_i = 0, stop_cmd_i = 0;
  logic switch_swap_i = 0, desync_i = 0, alarm_i = 0, mem_stage_i = 0, lim_r_i = 0;
  logic lim_l_i = 0, btn_r_i = 0, btn_l_i = 0, external_io_pin_dir_out_i = 0, external_io_pin_level_i = 0;
  logic brake_pwr_i = 0, rev_i = 0, sync_in_i = 0, sync_out_i = 0, enc_a_i = 0, enc_b_i = 0;
  logic [2:0] hall_i = '0;
  int err_count = 0, comparisons = 0, cycles = 0;
  csf_status dut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .step_count_i(step_count_i),
    .microstep_count_i(microstep_count_i), .encoder_count_i(encoder_count_i),
    .step_speed_i(step_speed_i), .microstep_speed_i(microstep_speed_i),
    .encoder_speed_i(encoder_speed_i), .sup_current_ma_i(sup_current_ma_i),
    .sup_voltage_10mv_i(sup_voltage_10mv_i), .usb_current_ma_i(usb_current_ma_i),
    .usb_voltage_10mv_i(usb_voltage_10mv_i), .temp_dc_i(temp_dc_i),
    .unknown_command_i(unknown_command_i), .bad_check_code_i(bad_check_code_i),
    .bad_value_i(bad_value_i), .stop_cmd_i(stop_cmd_i), .switch_swap_i(switch_swap_i),
    .desync_i(desync_i), .alarm_i(alarm_i), .crit_cond_i(crit_cond_i),
    .crit_autoclr_i(crit_autoclr_i), .mem_stage_i(mem_stage_i), .lim_r_i(lim_r_i),
    .lim_l_i(lim_l_i), .btn_r_i(btn_r_i), .btn_l_i(btn_l_i),
    .external_io_pin_dir_out_i(external_io_pin_dir_out_i), .external_io_pin_level_i(external_io_pin_level_i), .hall_i(hall_i),
    .brake_pwr_i(brake_pwr_i), .rev_i(rev_i), .sync_in_i(sync_in_i),
    .sync_out_i(sync_out_i), .enc_a_i(enc_a_i), .enc_b_i(enc_b_i),
    .query_done_o(query_done_o)
  );
  always #20 ref_clk_i = ~ref_clk_i;
  // ********************
  // Bus and compare tasks
  // ********************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    // Idle edge keeps a following strobe from rising in the same step
    @(posedge ref_clk_i);
  endtask
  // Data stand one cycle only, so sample just after the edge
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk(n, e, rdata_o);
    @(posedge ref_clk_i);
  endtask
  task automatic q;
    addr_i <= 8'h38;
    wdata_i <= 32'h0000_0000;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1 chk("done", 32'h1, {31'h0, query_done_o});
    @(posedge ref_clk_i);
  endtask
  // Bits: 0 unknown, 1 check code, 2 value, 3 stop, 4 switch swap, 5 desync
  task automatic pulse(input logic [5:0] v);
    {desync_i, switch_swap_i, stop_cmd_i, bad_value_i, bad_check_code_i, unknown_command_i} <= v;
    @(posedge ref_clk_i);
    {desync_i, switch_swap_i, stop_cmd_i, bad_value_i, bad_check_code_i, unknown_command_i} <= 6'h00;
    @(posedge ref_clk_i);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_meas;
    rc("flags", 8'h28, 32'h8000);
    sup_current_ma_i <= 16'h1234;
    sup_voltage_10mv_i <= 16'h05b9;
    usb_current_ma_i <= 16'h00a8;
    usb_voltage_10mv_i <= 16'h01e9;
    temp_dc_i <= 16'h00c0;
    q;
    temp_dc_i <= 16'h0fff;
    wr(8'h24, 32'hffffffff);
    rc("sup_i", 8'h14, 32'h1234);
    rc("sup_v", 8'h18, 32'h05b9);
    rc("usb_i", 8'h1c, 32'h00a8);
    rc("usb_v", 8'h20, 32'h01e9);
    rc("temp", 8'h24, 32'h00c0);
    rc("unmapped", 8'h40, 32'h0);
    $display("test meas done");
  endtask
  task automatic t_pos;
    logic fb;
    step_count_i <= 32'h100;
    microstep_count_i <= 9'h3;
    encoder_count_i <= 32'h2000;
    step_speed_i <= 32'h50;
    microstep_speed_i <= 9'h7;
    encoder_speed_i <= 32'h60;
    for (int m = 0; m < 4; m++) begin
      wr(8'h30, 32'(m));
      q;
      fb = m == 1 || m == 3;
      rc("pos", 8'h00, fb ? 32'h2000 : 32'h100);
      rc("microstep_position", 8'h04, fb ? 32'h0 : 32'h3);
      rc("sec", 8'h08, m == 0 ? 32'h2000 : m == 3 ? 32'h0 : 32'h100);
      rc("spd", 8'h0c, fb ? 32'h60 : 32'h50);
      rc("uspd", 8'h10, fb ? 32'h0 : 32'h7);
    end
    wr(8'h30, 32'hd);
    rc("ctrl", 8'h30, 32'h5);
    wr(8'h30, 32'h0);
    $display("test pos done");
  endtask
  task automatic t_sticky;
    pulse(6'h01);
    pulse(6'h02);
    pulse(6'h04);
    pulse(6'h10);
    pulse(6'h20);
    q;
    q;
    rc("flags", 8'h28, 32'hb007);
    pulse(6'h08);
    q;
    rc("flags", 8'h28, 32'h8000);
    pulse(6'h09);
    q;
    rc("flags", 8'h28, 32'h8001);
    pulse(6'h04);
    wr(8'h30, 32'h8);
    q;
    rc("flags", 8'h28, 32'h8000);
    wr(8'h30, 32'h4);
    desync_i <= 1'b1;
    @(posedge ref_clk_i);
    q;
    desync_i <= 1'b0;
    rc("flags", 8'h28, 32'ha000);
    q;
    rc("flags", 8'h28, 32'h8000);
    wr(8'h30, 32'h0);
    $display("test sticky done");
  endtask
  task automatic t_crit;
    crit_autoclr_i <= 8'hf0;
    crit_cond_i <= 8'hff;
    alarm_i <= 1'b1;
    mem_stage_i <= 1'b1;
    @(posedge ref_clk_i);
    q;
    rc("flags", 8'h28, 32'hcff8);
    crit_cond_i <= 8'h00;
    alarm_i <= 1'b0;
    mem_stage_i <= 1'b0;
    @(posedge ref_clk_i);
    q;
    rc("flags", 8'h28, 32'h80f0);
    pulse(6'h08);
    q;
    rc("flags", 8'h28, 32'h8000);
    $display("test crit done");
  endtask
  task automatic t_digital;
    {lim_r_i, btn_r_i, external_io_pin_dir_out_i, brake_pwr_i, sync_in_i, enc_a_i} <= 6'h3f;
    hall_i <= 3'h5;
    q;
    rc("digital", 8'h2c, 32'h2b55);
    enc_b_i <= 1'b1;
    wr(8'h34, 32'hff);
    rc("inv", 8'h34, 32'hff);
    q;
    rc("digital", 8'h2c, 32'h777a);
    $display("test digital done");
  endtask
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    t_meas();
    t_pos();
    t_sticky();
    t_crit();
    t_digital();
    finish_test();
  end
endmodule
